// file: verilog/macphy_cfg_regs.sv
`timescale 1ns/10ps
// Behaviour
// - size bit picks 32 or 64-bit timestamps
// - protection in chunk mode sends complements
// - protection in generic mode uses CRC8
// - protect bit read-only, latched from strap
// - retry disabled ignores header sequence bit
// - unchanged sequence bit means chunk rewrite
// - payload selector N gives 2^N bytes
// - payload size frozen once synced
// - report minimum payload in capability field
// - tx ready in generic mode only, on frame or FIFO empty
// - one bit picks PHY or MAC delimiter
// - second register offset, reset, reserved bits
// - zero PHY detection, one MAC detection
// - timestamp enable gates size selection
// - sync flag is write-one-to-set, reset clears
module macphy_cfg_regs
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic protect_strap,
   input wire logic protocol_generic,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [macphy_cfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [macphy_cfg_pkg::DATA_W-1:0] reg_wdata,
   output logic [macphy_cfg_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rdata_valid,
   input wire logic frame_transmitted,
   input wire logic tx_fifo_empty,
   input wire logic chunk_hdr_valid,
   input wire logic chunk_header_seq_bit,
   output logic timestamp_enable,
   output logic timestamp_64bit,
   output logic delimiter_from_mac,
   output logic [macphy_cfg_pkg::PAYLOAD_BYTES_W-1:0] payload_bytes,
   output logic [macphy_cfg_pkg::PAYLOAD_W-1:0] min_payload_cap,
   output logic control_complement_en,
   output logic crc8_en,
   output logic tx_ready_event,
   output logic chunk_rewrite,
   output logic config_synced
);
   import macphy_cfg_pkg::*;

   typedef struct packed
   {
      logic strap_done;
      logic protect;
      logic sync;
      logic ts_en;
      logic ts_size;
      logic seq_retry;
      logic [PAYLOAD_W-1:0] payload_sel;
      logic tx_rdy_empty;
      logic delim_src;
      logic fifo_empty_d;
      logic [DATA_W-1:0] rdata;
      logic rdata_valid;
      logic ts_64;
      logic cmp_en;
      logic crc_en;
      logic tx_ready_ev;
      logic [PAYLOAD_BYTES_W-1:0] bytes;
   } cfg_state_t;

   cfg_state_t st_reg;
   cfg_state_t st_next;
   logic wr_first;
   logic wr_second;
   logic [PAYLOAD_W-1:0] wr_sel;
   logic [DATA_W-1:0] first_word;
   logic [DATA_W-1:0] second_word;

   assign wr_first = reg_wr && (reg_addr == CONFIG_FIRST_ADDR);
   assign wr_second = reg_wr && (reg_addr == CONFIG_SECOND_ADDR);
   assign wr_sel = reg_wdata[PAYLOAD_LSB +: PAYLOAD_W];

   always_comb
   begin
      first_word = '0;
      first_word[SYNC_BIT] = st_reg.sync;
      first_word[TS_EN_BIT] = st_reg.ts_en;
      first_word[TS_SIZE_BIT] = st_reg.ts_size;
      first_word[PROTECT_BIT] = st_reg.protect;
      first_word[SEQ_RETRY_BIT] = st_reg.seq_retry;
      first_word[PAYLOAD_LSB +: PAYLOAD_W] = st_reg.payload_sel;
      second_word = '0;
      second_word[RESERVED2_LSB +: RESERVED2_W] = CONFIG_SECOND_RSVD;
      second_word[TX_RDY_EMPTY_BIT] = st_reg.tx_rdy_empty;
      second_word[DELIM_SRC_BIT] = st_reg.delim_src;
   end

   always_comb
   begin
      st_next = st_reg;
      // Strap is sampled on the first edge after release, never by reset
      if (!st_reg.strap_done)
      begin
         st_next.strap_done = 1'b1;
         st_next.protect = protect_strap;
      end
      if (wr_first)
      begin
         // Sync is set-only; nothing but reset clears it
         if (reg_wdata[SYNC_BIT])
         begin
            st_next.sync = 1'b1;
         end
         st_next.ts_en = reg_wdata[TS_EN_BIT];
         st_next.ts_size = reg_wdata[TS_SIZE_BIT];
         st_next.seq_retry = reg_wdata[SEQ_RETRY_BIT];
         // Out-of-range codes are dropped rather than clamped
         if (!st_reg.sync && wr_sel >= PAYLOAD_SEL_MIN
             && wr_sel <= PAYLOAD_SEL_MAX)
         begin
            st_next.payload_sel = wr_sel;
         end
      end
      if (wr_second)
      begin
         st_next.tx_rdy_empty = reg_wdata[TX_RDY_EMPTY_BIT];
         st_next.delim_src = reg_wdata[DELIM_SRC_BIT];
      end
      st_next.rdata_valid = reg_rd;
      if (reg_rd)
      begin
         case (reg_addr)
            CONFIG_FIRST_ADDR: st_next.rdata = first_word;
            CONFIG_SECOND_ADDR: st_next.rdata = second_word;
            default: st_next.rdata = '0;
         endcase
      end
      st_next.fifo_empty_d = tx_fifo_empty;
      st_next.tx_ready_ev = protocol_generic && (st_reg.tx_rdy_empty
         ? (tx_fifo_empty && !st_reg.fifo_empty_d)
         : frame_transmitted);
      st_next.ts_64 = st_next.ts_en && st_next.ts_size;
      st_next.cmp_en = st_next.protect && !protocol_generic;
      st_next.crc_en = st_next.protect && protocol_generic;
      st_next.bytes = PAYLOAD_BYTES_W'(1) << st_next.payload_sel;
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_reg <= '0;
         st_reg.payload_sel <= PAYLOAD_SEL_RESET;
         st_reg.bytes <= PAYLOAD_BYTES_W'(1) << PAYLOAD_SEL_RESET;
         st_reg.fifo_empty_d <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Tracking only runs in chunk mode with retry enabled
   chunk_seq_tracker u_seq
   (
      .core_clk(core_clk),
      .reset(reset),
      .enable(st_reg.seq_retry && !protocol_generic),
      .hdr_valid(chunk_hdr_valid),
      .seq_bit(chunk_header_seq_bit),
      .rewrite(chunk_rewrite)
   );

   assign reg_rdata = st_reg.rdata;
   assign reg_rdata_valid = st_reg.rdata_valid;
   assign timestamp_enable = st_reg.ts_en;
   assign timestamp_64bit = st_reg.ts_64;
   assign delimiter_from_mac = st_reg.delim_src;
   assign payload_bytes = st_reg.bytes;
   assign min_payload_cap = PAYLOAD_SEL_MIN;
   assign control_complement_en = st_reg.cmp_en;
   assign crc8_en = st_reg.crc_en;
   assign tx_ready_event = st_reg.tx_ready_ev;
   assign config_synced = st_reg.sync;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence empty_rise;
      protocol_generic && st_reg.tx_rdy_empty && tx_fifo_empty
         && !st_reg.fifo_empty_d;
   endsequence

   sequence read_second;
      reg_rd && reg_addr == CONFIG_SECOND_ADDR;
   endsequence

   a_protect_read_only: assert property (
      (st_reg.strap_done && wr_first) |=> $stable(st_reg.protect))
      else $error("protect bit changed by host write");

   a_payload_frozen: assert property (
      st_reg.sync |=> $stable(st_reg.payload_sel) && $stable(payload_bytes))
      else $error("payload size changed after sync");

   a_payload_range: assert property (
      st_reg.payload_sel >= PAYLOAD_SEL_MIN
         && st_reg.payload_sel <= PAYLOAD_SEL_MAX
         && payload_bytes == (PAYLOAD_BYTES_W'(1) << st_reg.payload_sel))
      else $error("payload selector or size out of range");

   a_sync_sticky: assert property (
      st_reg.sync |=> st_reg.sync [*2])
      else $error("sync flag cleared without reset");

   a_second_reserved: assert property (
      read_second |=> reg_rdata_valid
         && reg_rdata[DATA_W-1:RESERVED2_LSB] == CONFIG_SECOND_RSVD)
      else $error("reserved bits of second register wrong");

   a_ts_size_gate: assert property (
      wr_first |=> timestamp_64bit
         == ($past(reg_wdata[TS_EN_BIT]) && $past(reg_wdata[TS_SIZE_BIT])))
      else $error("64-bit timestamp without enable and size bit");

   a_ready_on_empty: assert property (
      empty_rise |=> tx_ready_event)
      else $error("no tx ready on FIFO going empty");

   a_ready_on_frame: assert property (
      (protocol_generic && !st_reg.tx_rdy_empty && frame_transmitted)
         |=> tx_ready_event)
      else $error("no tx ready after frame transmitted");

   a_ready_chunk_mode: assert property (
      !protocol_generic |=> !tx_ready_event)
      else $error("tx ready raised outside generic mode");

   a_delim_write: assert property (
      wr_second |=> delimiter_from_mac == $past(reg_wdata[DELIM_SRC_BIT]))
      else $error("delimiter source not taken from write");

   a_crc_mode: assert property (
      protocol_generic ##1 protocol_generic |-> crc8_en == st_reg.protect
         && !control_complement_en)
      else $error("CRC8 enable disagrees with protect in generic mode");

endmodule

// file: verilog/macphy_cfg_pkg.sv
package macphy_cfg_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [ADDR_W-1:0] CONFIG_FIRST_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] CONFIG_SECOND_ADDR = 8'h06;

   localparam int SYNC_BIT = 15;
   localparam int TS_EN_BIT = 7;
   localparam int TS_SIZE_BIT = 6;
   localparam int PROTECT_BIT = 5;
   localparam int SEQ_RETRY_BIT = 4;
   localparam int PAYLOAD_LSB = 0;
   localparam int PAYLOAD_W = 3;

   localparam int TX_RDY_EMPTY_BIT = 8;
   localparam int DELIM_SRC_BIT = 7;
   localparam int RESERVED2_LSB = 9;
   localparam int RESERVED2_W = 23;

   localparam logic [PAYLOAD_W-1:0] PAYLOAD_SEL_RESET = 3'h6;
   localparam logic [PAYLOAD_W-1:0] PAYLOAD_SEL_MIN = 3'h3;
   localparam logic [PAYLOAD_W-1:0] PAYLOAD_SEL_MAX = 3'h6;
   localparam int PAYLOAD_BYTES_W = 7;

   localparam logic [RESERVED2_W-1:0] CONFIG_SECOND_RSVD = 23'h000004;
   localparam logic [DATA_W-1:0] CONFIG_SECOND_RESET = 32'h00000800;

endpackage

// file: verilog/chunk_seq_tracker.sv
`timescale 1ns/10ps
module chunk_seq_tracker
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic hdr_valid,
   input wire logic seq_bit,
   output logic rewrite
);
   typedef struct packed
   {
      logic have_prev;
      logic prev_seq;
      logic rewrite;
   } seq_state_t;

   seq_state_t st_reg;
   seq_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.rewrite = 1'b0;
      if (!enable)
      begin
         // History is dropped so a re-enable never flags a stale match
         st_next.have_prev = 1'b0;
      end
      else if (hdr_valid)
      begin
         st_next.rewrite = st_reg.have_prev && (seq_bit == st_reg.prev_seq);
         st_next.have_prev = 1'b1;
         st_next.prev_seq = seq_bit;
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rewrite = st_reg.rewrite;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // Two headers on consecutive edges carrying the same sequence bit
   sequence two_same_seq;
      enable && hdr_valid ##1 enable && hdr_valid
         && seq_bit == $past(seq_bit);
   endsequence

   a_back_to_back: assert property (
      two_same_seq |=> rewrite)
      else $error("back-to-back equal sequence bits not flagged");

   a_rewrite_same_seq: assert property (
      (enable && hdr_valid && st_reg.have_prev && seq_bit == st_reg.prev_seq)
         |=> rewrite)
      else $error("repeated sequence bit not flagged as rewrite");

   a_rewrite_disabled: assert property (
      !enable |=> !rewrite)
      else $error("rewrite flagged while sequence tracking disabled");

   a_rewrite_needs_match: assert property (
      rewrite |-> $past(hdr_valid) && $past(enable))
      else $error("rewrite flagged without a chunk header");

endmodule

// file: test/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model
(
   input wire logic core_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [macphy_cfg_pkg::ADDR_W-1:0] reg_addr,
   output logic [macphy_cfg_pkg::DATA_W-1:0] reg_wdata
);
   import macphy_cfg_pkg::*;
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
   end
   // Selector is set before any traffic is started
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
      // Released data inverted so a stale value is never reused
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

// file: test/spi_macphy_config_fields_test.sv
`timescale 1ns/10ps
module spi_macphy_config_fields_test;
   import macphy_cfg_pkg::*;
   logic core_clk, reset, protect_strap, protocol_generic;
   logic reg_wr, reg_rd, reg_rdata_valid, frame_transmitted;
   logic tx_fifo_empty, chunk_hdr_valid, chunk_header_seq_bit;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, w;
   logic timestamp_enable, timestamp_64bit, delimiter_from_mac;
   logic [PAYLOAD_BYTES_W-1:0] payload_bytes;
   logic [PAYLOAD_W-1:0] min_payload_cap;
   logic control_complement_en, crc8_en, tx_ready_event;
   logic chunk_rewrite, config_synced, s, prev;
   logic [DATA_W-1:0] exp_q[$];
   int err_total = 0;
   int n_checks = 0;

   spi_host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   macphy_cfg_regs u_dut (.core_clk(core_clk), .reset(reset),
      .protect_strap(protect_strap), .protocol_generic(protocol_generic),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rdata_valid(reg_rdata_valid),
      .frame_transmitted(frame_transmitted), .tx_fifo_empty(tx_fifo_empty),
      .chunk_hdr_valid(chunk_hdr_valid),
      .chunk_header_seq_bit(chunk_header_seq_bit),
      .timestamp_enable(timestamp_enable), .timestamp_64bit(timestamp_64bit),
      .delimiter_from_mac(delimiter_from_mac), .payload_bytes(payload_bytes),
      .min_payload_cap(min_payload_cap),
      .control_complement_en(control_complement_en), .crc8_en(crc8_en),
      .tx_ready_event(tx_ready_event), .chunk_rewrite(chunk_rewrite),
      .config_synced(config_synced));

   task automatic check(string nm, logic [31:0] seen, logic [31:0] e);
      n_checks++;
      if (seen !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task automatic rd_exp(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      u_host.rd(a);
   endtask
   task automatic step;
      @(posedge core_clk);
      #1;
   endtask
   task automatic summarize;
      if (exp_q.size() != 0)
         err_total++;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever
         #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (reg_rdata_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("reg_rdata extra", reg_rdata, 32'h0);
         else
            check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
   initial
   begin
      #50000;
      err_total++;
      summarize();
   end

   initial
   begin
      reset = 1'b1;
      protect_strap = 1'b1;
      protocol_generic = 1'b0;
      frame_transmitted = 1'b0;
      tx_fifo_empty = 1'b1;
      chunk_hdr_valid = 1'b0;
      chunk_header_seq_bit = 1'b0;
      void'($urandom(16573));
      repeat (16) @(posedge core_clk);
      #1;
      reset = 1'b0;
      repeat (2) step();
      rd_exp(CONFIG_FIRST_ADDR, 32'h00000026);
      rd_exp(CONFIG_SECOND_ADDR, 32'h00000800);
      check("payload", payload_bytes, 32'h40);
      check("min_cap", min_payload_cap, 32'h3);
      check("complement", control_complement_en, 32'h1);
      check("crc8", crc8_en, 32'h0);
      check("delim", delimiter_from_mac, 32'h0);
      check("synced", config_synced, 32'h0);
      $display("test reset done");
      u_host.wr(CONFIG_FIRST_ADDR, 32'h00000003);
      check("payload", payload_bytes, 32'h08);
      u_host.wr(CONFIG_FIRST_ADDR, 32'h00008005);
      check("payload", payload_bytes, 32'h20);
      u_host.wr(CONFIG_FIRST_ADDR, 32'h00000004);
      check("payload", payload_bytes, 32'h20);
      check("synced", config_synced, 32'h1);
      u_host.wr(CONFIG_FIRST_ADDR, 32'hffffffdf);
      rd_exp(CONFIG_FIRST_ADDR, 32'h000080f5);
      check("ts64", timestamp_64bit, 32'h1);
      u_host.wr(CONFIG_FIRST_ADDR, 32'h00000040);
      check("ts_en", timestamp_enable, 32'h0);
      check("ts64", timestamp_64bit, 32'h0);
      $display("test first register done");
      w = $urandom;
      u_host.wr(CONFIG_SECOND_ADDR, w);
      rd_exp(CONFIG_SECOND_ADDR, 32'h800 | (w & 32'h180));
      check("delim", delimiter_from_mac, {31'h0, w[7]});
      rd_exp(8'h10, 32'h0);
      $display("test second register done");
      protocol_generic = 1'b1;
      u_host.wr(CONFIG_SECOND_ADDR, 32'h0);
      check("crc8", crc8_en, 32'h1);
      check("complement", control_complement_en, 32'h0);
      frame_transmitted = 1'b1;
      step();
      frame_transmitted = 1'b0;
      check("tx_ready", tx_ready_event, 32'h1);
      step();
      check("tx_ready", tx_ready_event, 32'h0);
      u_host.wr(CONFIG_SECOND_ADDR, 32'h100);
      tx_fifo_empty = 1'b0;
      frame_transmitted = 1'b1;
      step();
      frame_transmitted = 1'b0;
      check("tx_ready", tx_ready_event, 32'h0);
      tx_fifo_empty = 1'b1;
      step();
      check("tx_ready", tx_ready_event, 32'h1);
      protocol_generic = 1'b0;
      $display("test tx ready done");
      for (int en = 1; en >= 0; en--)
      begin
         u_host.wr(CONFIG_FIRST_ADDR, en ? 32'h8010 : 32'h8000);
         step();
         for (int i = 0; i < 8; i++)
         begin
            s = 1'($urandom);
            chunk_hdr_valid = 1'b1;
            chunk_header_seq_bit = s;
            step();
            check("rewrite", chunk_rewrite, (en && i > 0 && s == prev));
            prev = s;
         end
         chunk_hdr_valid = 1'b0;
      end
      $display("test chunk sequence done");
      reset = 1'b1;
      step();
      reset = 1'b0;
      check("synced", config_synced, 32'h0);
      check("payload", payload_bytes, 32'h40);
      repeat (2) step();
      u_host.wr(CONFIG_FIRST_ADDR, 32'h00000003);
      check("payload", payload_bytes, 32'h08);
      $display("test reset again done");
      repeat (3) step();
      summarize();
   end
endmodule
